// *** core/top_ctrl_pkg.sv ***
// constants and field layout of the top-level control register bank
// Operation
// [RULE1] supply source field routes system rail: 00 max, 01 battery, 10 input, 11 open.
// [RULE2] over-voltage bit picks 5.50 V clear or 6.0 V set; resets clear.
// [RULE3] input under-voltage field picks 2.9 to 3.5 V in 0.2 V steps; resets 01.
// [RULE4] system-rail under-voltage field picks 2.4 to 2.7 V; resets 11.
// [RULE5] thermal shutdown field 95 to 125 C, 5 C steps, 20 C hysteresis; resets 011.
// [RULE6] die warning field picks 75 to 90 C in 5 C steps; resets 10.
// [RULE7] pin selection off: mode comes from the two register bits, high bit first.
// [RULE8] pin selection on: mode comes from the external mode pins instead.
// [RULE9] writing one to soft reset restores all defaults and power-cycles regulators.
// [RULE10] soft reset bit clears itself, so later reads return zero.
// [RULE11] long-press field sets 4, 8, 12 or 16 seconds; resets 01.
// [RULE12] host reads back the last written value of every field.
// [RULE13] writing zero to soft reset does nothing; reserved bits keep values unless written.
`default_nettype none

package top_ctrl_pkg;

    // ========================================
    // register offsets
    localparam logic [7:0] SUPPLY_PROTECTION_CONFIG_ADDR = 8'h0a;
    localparam logic [7:0] THERMAL_AND_RAIL_LIMITS_ADDR  = 8'h0b;
    localparam logic [7:0] MODE_RESET_KEY_CONTROL_ADDR   = 8'h0c;

    // ========================================
    // reset values
    localparam logic [7:0] SUPPLY_PROTECTION_CONFIG_RST  = 8'h09;
    localparam logic [7:0] THERMAL_AND_RAIL_LIMITS_RST   = 8'hce;
    localparam logic [7:0] MODE_RESET_KEY_CONTROL_RST    = 8'h01;

    // ========================================
    // field positions (low bit of each field)
    localparam int SUPPLY_SRC_LSB   = 4;
    localparam int OVP_BIT          = 2;
    localparam int INPUT_UVLO_LSB   = 0;
    localparam int RAIL_UVLO_LSB    = 6;
    localparam int SHUTDOWN_TEMP_LSB = 2;
    localparam int WARN_LSB         = 0;
    localparam int MODE_HIGH_BIT    = 4;
    localparam int MODE_LOW_BIT     = 3;
    localparam int SOFT_RESET_BIT   = 2;
    localparam int LONG_PRESS_LSB   = 0;

    // ========================================
    // threshold scales
    localparam logic [15:0] OVP_LOW_MV       = 16'h157c;  // 5500 mV
    localparam logic [15:0] OVP_HIGH_MV      = 16'h1770;  // 6000 mV
    localparam logic [15:0] INPUT_UVLO_BASE_MV = 16'h0b54; // 2900 mV
    localparam logic [15:0] INPUT_UVLO_STEP_MV = 16'h00c8; // 200 mV
    localparam logic [15:0] RAIL_UVLO_BASE_MV = 16'h0960; // 2400 mV
    localparam logic [15:0] RAIL_UVLO_STEP_MV = 16'h0064; // 100 mV
    localparam logic [7:0]  SHUTDOWN_TEMP_BASE_C   = 8'h5f;  // 95 C
    localparam logic [7:0]  TEMP_STEP_C            = 8'h05;
    localparam logic [7:0]  SHUTDOWN_TEMP_HYST_C   = 8'h14;  // 20 C
    localparam logic [2:0]  SHUTDOWN_TEMP_RESERVED = 3'h7;
    localparam logic [7:0]  WARN_BASE_C      = 8'h4b;     // 75 C

    // ========================================
    // supply routing
    typedef enum logic [1:0] {
        SRC_MAX_INPUT_PREF = 2'b00,
        SRC_BATTERY_ONLY   = 2'b01,
        SRC_INPUT_ONLY     = 2'b10,
        SRC_DISCONNECT     = 2'b11
    } supply_src_t;

    // ========================================
    // timing
    localparam longint CLK_FREQ_HZ          = 50_000_000;
    localparam longint LONG_PRESS_STEP_S    = 4;
    localparam longint LONG_PRESS_STEP_CYC  = LONG_PRESS_STEP_S * CLK_FREQ_HZ;
    localparam longint REG_OFF_TIME_US      = 1000;
    localparam longint REG_OFF_CYC          = (REG_OFF_TIME_US * CLK_FREQ_HZ) / 1_000_000;

endpackage : top_ctrl_pkg

`default_nettype wire

// *** core/regulator_cycle_seq.sv ***
// regulator power-cycle sequencer started by a soft reset
`timescale 1ns/10ps
`default_nettype none

module regulator_cycle_seq
    import top_ctrl_pkg::*;
#(
    parameter int OFF_CYCLES = 32'(REG_OFF_CYC)
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // trigger
    input  wire logic i_start,
    // regulator control
    output logic      o_regulator_off
);

    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_OFF  = 1'b1
    } seq_state_t;

    seq_state_t  state_r;
    logic [31:0] count_r;

    // ========================================
    // off window
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= SEQ_IDLE;
            count_r <= 32'h0;
        end else begin
            case (state_r)
                SEQ_IDLE: begin
                    if (i_start) begin  // see [RULE9]
                        state_r <= SEQ_OFF;
                        count_r <= 32'(OFF_CYCLES - 1);
                    end
                end
                SEQ_OFF: begin
                    if (i_start) begin
                        count_r <= 32'(OFF_CYCLES - 1);
                    end else if (count_r == 32'h0) begin
                        state_r <= SEQ_IDLE;
                    end else begin
                        count_r <= count_r - 32'h1;
                    end
                end
                default: begin
                    state_r <= SEQ_IDLE;
                end
            endcase
        end
    end

    assign o_regulator_off = (state_r == SEQ_OFF);

    // ========================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_off_starts: assert property (i_start |=> o_regulator_off) // see [RULE9]
        else $error("regulators not cut after soft reset");
    a_off_ends: assert property (o_regulator_off && count_r == 32'h0 && !i_start
                                 |=> !o_regulator_off) // see [RULE9]
        else $error("regulator off window overran");

endmodule : regulator_cycle_seq

`default_nettype wire

// *** core/pmic_top_control_regs.sv ***
// top-level control register bank: supply, protection, thermal, mode, soft reset
`timescale 1ns/10ps
`default_nettype none

module pmic_top_control_regs
    import top_ctrl_pkg::*;
#(
    parameter int REG_OFF_CYCLES       = 32'(REG_OFF_CYC),
    parameter int LONG_PRESS_STEP_CYCS = 32'(LONG_PRESS_STEP_CYC)
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // register port from the serial slave
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wr_data,
    output logic      [7:0]  o_rd_data,
    output logic             o_rd_valid,
    // mode selection
    input  wire logic        i_pin_mode_select_enable,
    input  wire logic [1:0]  i_external_mode_pin,
    output logic      [1:0]  o_operating_mode,
    // supply and protection settings
    output logic      [1:0]  o_supply_source_select,
    output logic             o_battery_path_on,
    output logic             o_input_path_on,
    output logic             o_input_preferred,
    output logic      [15:0] o_input_overvoltage_mv,
    output logic      [15:0] o_input_undervoltage_mv,
    output logic      [15:0] o_system_rail_undervoltage_mv,
    // thermal settings
    output logic      [7:0]  o_shutdown_temperature_rise_c,
    output logic      [7:0]  o_shutdown_temperature_fall_c,
    output logic             o_shutdown_level_reserved,
    output logic      [7:0]  o_die_warning_c,
    // power key
    output logic      [31:0] o_power_key_long_press_cycles,
    // soft reset
    output logic             o_soft_reset_pulse,
    output logic             o_regulator_off
);

    logic [7:0] supply_protection_config_r;
    logic [7:0] thermal_and_rail_limits_r;
    logic [7:0] mode_reset_key_control_r;
    logic       hit_ctl1;
    logic       hit_ctl2;
    logic       hit_ctl3;
    logic       soft_reset_hit;
    logic [7:0] rd_data_nxt;

    logic [1:0] supply_source_select;
    logic       input_overvoltage_level;
    logic [1:0] input_undervoltage_level;
    logic [1:0] system_rail_undervoltage_level;
    logic [2:0] thermal_shutdown_level;
    logic [1:0] die_warning_level;
    logic       mode_select_high;
    logic       mode_select_low;
    logic [1:0] power_key_long_press_time;

    // ========================================
    // address decode
    assign hit_ctl1       = (i_addr == SUPPLY_PROTECTION_CONFIG_ADDR);
    assign hit_ctl2       = (i_addr == THERMAL_AND_RAIL_LIMITS_ADDR);
    assign hit_ctl3       = (i_addr == MODE_RESET_KEY_CONTROL_ADDR);
    assign soft_reset_hit = i_wr_en && hit_ctl3 && i_wr_data[SOFT_RESET_BIT];  // see [RULE9]

    // ========================================
    // supply and protection register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            supply_protection_config_r <= SUPPLY_PROTECTION_CONFIG_RST;  // see [RULE2] see [RULE3]
        end else if (soft_reset_hit) begin
            supply_protection_config_r <= SUPPLY_PROTECTION_CONFIG_RST;  // see [RULE9]
        end else if (i_wr_en && hit_ctl1) begin
            supply_protection_config_r <= i_wr_data;  // see [RULE12] see [RULE13]
        end
    end

    // ========================================
    // thermal and rail limit register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            thermal_and_rail_limits_r <= THERMAL_AND_RAIL_LIMITS_RST;  // see [RULE4] see [RULE5]
        end else if (soft_reset_hit) begin
            thermal_and_rail_limits_r <= THERMAL_AND_RAIL_LIMITS_RST;  // see [RULE9]
        end else if (i_wr_en && hit_ctl2) begin
            thermal_and_rail_limits_r <= i_wr_data;  // see [RULE12]
        end
    end

    // ========================================
    // mode, soft reset and key register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_reset_key_control_r <= MODE_RESET_KEY_CONTROL_RST;  // see [RULE11]
        end else if (soft_reset_hit) begin
            mode_reset_key_control_r <= MODE_RESET_KEY_CONTROL_RST;  // see [RULE9] see [RULE10]
        end else if (i_wr_en && hit_ctl3) begin
            // the trigger bit never stores; a zero write leaves it and all else plain
            mode_reset_key_control_r <= i_wr_data & ~(8'h01 << SOFT_RESET_BIT);  // see [RULE13]
        end
    end

    // ========================================
    // field extraction
    assign supply_source_select = supply_protection_config_r[SUPPLY_SRC_LSB +: 2];
    assign input_overvoltage_level  = supply_protection_config_r[OVP_BIT];
    assign input_undervoltage_level = supply_protection_config_r[INPUT_UVLO_LSB +: 2];
    assign system_rail_undervoltage_level = thermal_and_rail_limits_r[RAIL_UVLO_LSB +: 2];
    assign thermal_shutdown_level   = thermal_and_rail_limits_r[SHUTDOWN_TEMP_LSB +: 3];
    assign die_warning_level        = thermal_and_rail_limits_r[WARN_LSB +: 2];
    assign mode_select_high         = mode_reset_key_control_r[MODE_HIGH_BIT];
    assign mode_select_low          = mode_reset_key_control_r[MODE_LOW_BIT];
    assign power_key_long_press_time = mode_reset_key_control_r[LONG_PRESS_LSB +: 2];

    // ========================================
    // read path
    always_comb begin
        rd_data_nxt = 8'h00;
        if (hit_ctl1) begin
            rd_data_nxt = supply_protection_config_r;  // see [RULE12]
        end else if (hit_ctl2) begin
            rd_data_nxt = thermal_and_rail_limits_r;
        end else if (hit_ctl3) begin
            rd_data_nxt = mode_reset_key_control_r;  // see [RULE10]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_data  <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en) begin
                o_rd_data <= rd_data_nxt;
            end
        end
    end

    // ========================================
    // operating mode selection
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_operating_mode <= 2'b00;
        end else if (i_pin_mode_select_enable) begin
            o_operating_mode <= i_external_mode_pin;  // see [RULE8]
        end else begin
            o_operating_mode <= {mode_select_high, mode_select_low};  // see [RULE7]
        end
    end

    // ========================================
    // supply routing
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_supply_source_select <= 2'b00;
            o_battery_path_on      <= 1'b0;
            o_input_path_on        <= 1'b0;
            o_input_preferred      <= 1'b0;
        end else begin
            o_supply_source_select <= supply_source_select;
            case (supply_src_t'(supply_source_select))  // see [RULE1]
                SRC_MAX_INPUT_PREF: begin
                    o_battery_path_on <= 1'b1;
                    o_input_path_on   <= 1'b1;
                    o_input_preferred <= 1'b1;
                end
                SRC_BATTERY_ONLY: begin
                    o_battery_path_on <= 1'b1;
                    o_input_path_on   <= 1'b0;
                    o_input_preferred <= 1'b0;
                end
                SRC_INPUT_ONLY: begin
                    o_battery_path_on <= 1'b0;
                    o_input_path_on   <= 1'b1;
                    o_input_preferred <= 1'b1;
                end
                default: begin
                    o_battery_path_on <= 1'b0;
                    o_input_path_on   <= 1'b0;
                    o_input_preferred <= 1'b0;
                end
            endcase
        end
    end

    // ========================================
    // voltage thresholds
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_input_overvoltage_mv        <= 16'h0000;
            o_input_undervoltage_mv       <= 16'h0000;
            o_system_rail_undervoltage_mv <= 16'h0000;
        end else begin
            o_input_overvoltage_mv <= input_overvoltage_level ? OVP_HIGH_MV
                                                              : OVP_LOW_MV;  // see [RULE2]
            o_input_undervoltage_mv <= 16'(INPUT_UVLO_BASE_MV
                + INPUT_UVLO_STEP_MV * 16'(input_undervoltage_level));  // see [RULE3]
            o_system_rail_undervoltage_mv <= 16'(RAIL_UVLO_BASE_MV
                + RAIL_UVLO_STEP_MV * 16'(system_rail_undervoltage_level));  // see [RULE4]
        end
    end

    // ========================================
    // thermal thresholds
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_shutdown_temperature_rise_c <= 8'h00;
            o_shutdown_temperature_fall_c <= 8'h00;
            o_shutdown_level_reserved     <= 1'b0;
            o_die_warning_c               <= 8'h00;
        end else begin
            o_shutdown_temperature_rise_c <= 8'(SHUTDOWN_TEMP_BASE_C
                + TEMP_STEP_C * 8'(thermal_shutdown_level));  // see [RULE5]
            o_shutdown_temperature_fall_c <= 8'(SHUTDOWN_TEMP_BASE_C - SHUTDOWN_TEMP_HYST_C
                + TEMP_STEP_C * 8'(thermal_shutdown_level));  // see [RULE5]
            o_shutdown_level_reserved <= (thermal_shutdown_level == SHUTDOWN_TEMP_RESERVED);
            o_die_warning_c <= 8'(WARN_BASE_C
                + TEMP_STEP_C * 8'(die_warning_level));  // see [RULE6]
        end
    end

    // ========================================
    // power key long-press time
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_power_key_long_press_cycles <= 32'h0;
        end else begin
            o_power_key_long_press_cycles <= 32'(LONG_PRESS_STEP_CYCS)
                * (32'(power_key_long_press_time) + 32'h1);  // see [RULE11]
        end
    end

    // ========================================
    // soft reset outputs
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_soft_reset_pulse <= 1'b0;
        end else begin
            o_soft_reset_pulse <= soft_reset_hit;  // see [RULE9]
        end
    end

    regulator_cycle_seq #(
        .OFF_CYCLES      (REG_OFF_CYCLES)
    ) u_regulator_cycle_seq (
        .i_clk           (i_clk),
        .i_rst           (i_rst),
        .i_start         (soft_reset_hit),
        .o_regulator_off (o_regulator_off)
    );

    // ========================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_srst_restores_all: assert property (soft_reset_hit |=>
        supply_protection_config_r == SUPPLY_PROTECTION_CONFIG_RST
        && thermal_and_rail_limits_r == THERMAL_AND_RAIL_LIMITS_RST
        && mode_reset_key_control_r == MODE_RESET_KEY_CONTROL_RST) // see [RULE9]
        else $error("soft reset left a register off default");

    a_srst_reads_zero: assert property (i_rd_en && hit_ctl3
        |=> o_rd_valid && !o_rd_data[SOFT_RESET_BIT]) // see [RULE10]
        else $error("soft reset bit read back as one");

    a_zero_write_noop: assert property (i_wr_en && hit_ctl3 && !i_wr_data[SOFT_RESET_BIT]
        |=> supply_protection_config_r == $past(supply_protection_config_r)
        && !o_soft_reset_pulse) // see [RULE13]
        else $error("zero write to soft reset had an effect");

    a_write_readback: assert property (i_wr_en && hit_ctl2
        ##1 (i_rd_en && hit_ctl2 && !i_wr_en)
        |=> o_rd_data == $past(i_wr_data, 2)) // see [RULE12]
        else $error("read did not return last written value");

    a_mode_from_bits: assert property (!i_pin_mode_select_enable
        |=> o_operating_mode == $past({mode_select_high, mode_select_low})) // see [RULE7]
        else $error("mode not taken from register bits");

    a_mode_from_pins: assert property (i_pin_mode_select_enable
        |=> o_operating_mode == $past(i_external_mode_pin)) // see [RULE8]
        else $error("mode not taken from pins");

    a_ovp_level: assert property (!i_rst |=> o_input_overvoltage_mv ==
        ($past(input_overvoltage_level) ? 16'h1770 : 16'h157c)) // see [RULE2]
        else $error("overvoltage threshold wrong");

    a_shutdown_hyst: assert property (!i_rst |=> o_shutdown_temperature_rise_c
        == 8'(o_shutdown_temperature_fall_c + 8'h14)) // see [RULE5]
        else $error("thermal hysteresis not 20 degrees");

    a_source_routing: assert property (supply_source_select == 2'b01
        |=> o_battery_path_on && !o_input_path_on) // see [RULE1]
        else $error("battery-only routing wrong");

    a_reset_defaults: assert property ($past(i_rst) |->
        input_undervoltage_level == 2'b01 && system_rail_undervoltage_level == 2'b11
        && die_warning_level == 2'b10 && power_key_long_press_time == 2'b01) // see [RULE3]
        else $error("field defaults wrong after reset");

    c_soft_reset: cover property (soft_reset_hit ##1 o_regulator_off);
    c_pin_mode: cover property (i_pin_mode_select_enable ##1 o_operating_mode == 2'b11);
    c_ctl2_write_read: cover property (i_wr_en && hit_ctl2 ##1 i_rd_en && hit_ctl2);
    c_disconnect: cover property (supply_source_select == 2'b11);

endmodule : pmic_top_control_regs

`default_nettype wire

// *** tb/host_model.sv ***
// host-side model driving the register port of the control bank
`timescale 1ns/10ps
`default_nettype none

module host_model (
    // clock
    input  wire logic       i_clk,
    // register port toward the bank
    output var  logic       o_wr_en,
    output var  logic       o_rd_en,
    output var  logic [7:0] o_addr,
    output var  logic [7:0] o_wr_data,
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_valid
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wr_data = 8'h00;
    end

    // one byte, strobe seen at exactly one edge; released lines show the inverse
    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        o_wr_en <= 1'b1;
        o_addr <= addr;
        o_wr_data <= data;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
        o_addr <= ~addr;
        o_wr_data <= ~data;
    endtask : write

    task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic vld);
        @(posedge i_clk);
        o_rd_en <= 1'b1;
        o_addr <= addr;
        @(posedge i_clk);
        o_rd_en <= 1'b0;
        o_addr <= ~addr;
        #1;
        vld = i_rd_valid;
        data = i_rd_data;
    endtask : read

    // write strobe at one edge, read strobe at the very next one
    task automatic write_read(input logic [7:0] addr, input logic [7:0] data,
                              output logic [7:0] rdat, output logic vld);
        @(posedge i_clk);
        o_wr_en <= 1'b1;
        o_addr <= addr;
        o_wr_data <= data;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
        o_rd_en <= 1'b1;
        o_wr_data <= ~data;
        @(posedge i_clk);
        o_rd_en <= 1'b0;
        o_addr <= ~addr;
        #1;
        vld = i_rd_valid;
        rdat = i_rd_data;
    endtask : write_read
endmodule : host_model

`default_nettype wire

// *** tb/tb_pmic_top_control_regs.sv ***
// self-checking bench for the top-level control register bank
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR at %0t: got %0h expected %0h", $time, got, exp); end end

module tb_pmic_top_control_regs;
    import top_ctrl_pkg::*;
    localparam logic [7:0] A_SUP = SUPPLY_PROTECTION_CONFIG_ADDR;
    localparam logic [7:0] A_LIM = THERMAL_AND_RAIL_LIMITS_ADDR;
    localparam logic [7:0] A_MOD = MODE_RESET_KEY_CONTROL_ADDR;

    // ========================================
    // signals
    logic        i_clk = 1'b0, i_rst = 1'b1, i_wr_en, i_rd_en, o_rd_valid;
    logic [7:0]  i_addr, i_wr_data, o_rd_data;
    logic        i_pin_mode_select_enable = 1'b0;
    logic [1:0]  i_external_mode_pin = 2'h0, o_operating_mode, o_supply_source_select;
    logic        o_battery_path_on, o_input_path_on, o_input_preferred;
    logic [15:0] o_input_overvoltage_mv, o_input_undervoltage_mv, o_system_rail_undervoltage_mv;
    logic [7:0]  o_shutdown_temperature_rise_c, o_shutdown_temperature_fall_c, o_die_warning_c;
    logic        o_shutdown_level_reserved, o_soft_reset_pulse, o_regulator_off;
    logic [31:0] o_power_key_long_press_cycles;
    int          num_errors = 0;
    int          compares = 0;

    always #10 i_clk = ~i_clk;

    pmic_top_control_regs #(.REG_OFF_CYCLES(4), .LONG_PRESS_STEP_CYCS(10)) i_dut (
        .i_clk, .i_rst, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data, .o_rd_data, .o_rd_valid,
        .i_pin_mode_select_enable, .i_external_mode_pin, .o_operating_mode,
        .o_supply_source_select, .o_battery_path_on, .o_input_path_on, .o_input_preferred,
        .o_input_overvoltage_mv, .o_input_undervoltage_mv, .o_system_rail_undervoltage_mv,
        .o_shutdown_temperature_rise_c, .o_shutdown_temperature_fall_c,
        .o_shutdown_level_reserved, .o_die_warning_c, .o_power_key_long_press_cycles,
        .o_soft_reset_pulse, .o_regulator_off
    );

    host_model i_host (
        .i_clk, .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr),
        .o_wr_data(i_wr_data), .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid)
    );

    // ========================================
    // helpers
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : wait_cyc

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        i_host.read(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, exp)
    endtask : rd_chk

    // ========================================
    // scenarios
    task automatic t_reset;
        rd_chk(A_SUP, 8'h09);
        rd_chk(A_LIM, 8'hce);
        rd_chk(A_MOD, 8'h01);
        `CHK(o_input_overvoltage_mv, 16'h157c)
        `CHK(o_input_undervoltage_mv, 16'h0c1c)
        `CHK(o_system_rail_undervoltage_mv, 16'h0a8c)
        `CHK(o_shutdown_temperature_rise_c, 8'h6e)
        `CHK(o_die_warning_c, 8'h55)
        `CHK(o_power_key_long_press_cycles, 32'h14)
        `CHK(o_operating_mode, 2'h0)
        $display("test reset_defaults done");
    endtask : t_reset

    task automatic t_supply;
        logic [2:0] paths [4] = '{3'h7, 3'h4, 3'h3, 3'h0};
        logic [1:0] k;
        for (int c = 0; c < 4; c++) begin
            k = 2'(c);
            i_host.write(A_SUP, {2'h0, k, 1'b1, k[0], k});
            rd_chk(A_SUP, {2'h0, k, 1'b1, k[0], k});
            `CHK(o_supply_source_select, k)
            `CHK(({o_battery_path_on, o_input_path_on, o_input_preferred}), paths[c])
            `CHK(o_input_overvoltage_mv, k[0] ? 16'h1770 : 16'h157c)
            `CHK(o_input_undervoltage_mv, 16'h0b54 + 16'(k) * 16'h00c8)
        end
        $display("test supply_protection done");
    endtask : t_supply

    task automatic t_thermal;
        logic [2:0] k;
        logic [7:0] w;
        logic [7:0] d;
        logic       v;
        for (int c = 0; c < 8; c++) begin
            k = 3'(c);
            w = {k[1:0], 1'b0, k, k[1:0]};
            // write then read on back-to-back edges
            i_host.write_read(A_LIM, w, d, v);
            `CHK(v, 1'b1)
            `CHK(d, w)
            `CHK(o_system_rail_undervoltage_mv, 16'h0960 + 16'(k[1:0]) * 16'h0064)
            `CHK(o_shutdown_temperature_rise_c, 8'h5f + 8'(k) * 8'h05)
            `CHK(o_shutdown_temperature_fall_c, 8'h4b + 8'(k) * 8'h05)
            `CHK(o_shutdown_level_reserved, k == 3'h7)
            `CHK(o_die_warning_c, 8'h4b + 8'(k[1:0]) * 8'h05)
        end
        $display("test thermal_limits done");
    endtask : t_thermal

    task automatic t_mode;
        logic [1:0] k;
        for (int c = 0; c < 4; c++) begin
            k = 2'(c);
            i_host.write(A_MOD, {3'h0, k, 1'b0, k});
            rd_chk(A_MOD, {3'h0, k, 1'b0, k});
            `CHK(o_operating_mode, k)
            `CHK(o_power_key_long_press_cycles, 32'(k) * 32'h0a + 32'h0a)
            @(posedge i_clk);
            i_pin_mode_select_enable <= 1'b1;
            i_external_mode_pin <= ~k;
            wait_cyc(1);
            `CHK(o_operating_mode, ~k)
            @(posedge i_clk);
            i_pin_mode_select_enable <= 1'b0;
        end
        $display("test mode_select done");
    endtask : t_mode

    task automatic t_soft;
        i_host.write(A_SUP, 8'h3f);
        i_host.write(A_LIM, 8'h00);
        i_host.write(A_MOD, 8'h1f);
        #1;
        `CHK(({o_soft_reset_pulse, o_regulator_off}), 2'h3)
        wait_cyc(1);
        `CHK(({o_soft_reset_pulse, o_regulator_off}), 2'h1)
        wait_cyc(2);
        `CHK(o_regulator_off, 1'b1)
        wait_cyc(1);
        `CHK(o_regulator_off, 1'b0)
        rd_chk(A_SUP, 8'h09);
        rd_chk(A_LIM, 8'hce);
        rd_chk(A_MOD, 8'h01);
        i_host.write(A_MOD, 8'hfb);
        #1;
        `CHK(o_soft_reset_pulse, 1'b0)
        rd_chk(A_MOD, 8'hfb);
        rd_chk(A_SUP, 8'h09);
        i_host.write(8'h0d, 8'hff);
        rd_chk(8'h0d, 8'h00);
        rd_chk(A_LIM, 8'hce);
        $display("test soft_reset done");
    endtask : t_soft

    task automatic close_out;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_supply();
        t_thermal();
        t_mode();
        t_soft();
        close_out();
    end

    // tests need about 120 cycles; cut off well beyond that
    initial begin
        repeat (3000) @(posedge i_clk);
        $display("ERROR at %0t: watchdog expired", $time);
        num_errors++;
        close_out();
    end
endmodule : tb_pmic_top_control_regs

`default_nettype wire
